/* core/mem_map_decoder.v */
// program/data memory map decoder with rom, dual-access ram and page extension
`timescale 1ns/100ps
`default_nettype none
`include "mmap_regs.vh"
module mem_map_decoder (
  input wire mclk,
  input wire rst_b,
  input wire boot_mode_select_pin,
  input wire pf_req,
  input wire [15:0] pf_pc,
  input wire tbl_req,
  input wire tbl_we,
  input wire [15:0] tbl_wdata,
  input wire [19:0] accum,
  input wire da_req,
  input wire da_we,
  input wire [15:0] da_addr,
  input wire [15:0] da_wdata,
  input wire far_req,
  input wire [2:0] far_op,
  input wire [19:0] far_imm,
  input wire [19:0] far_ret,
  input wire vec_req,
  input wire [4:0] vec_num,
  input wire rom_load_en,
  input wire [11:0] rom_load_addr,
  input wire [15:0] rom_load_data,
  output reg [15:0] pa_rdata_ff,
  output reg pa_valid_ff,
  output reg pa_ext_ff,
  output reg pa_we_ff,
  output reg [15:0] pa_wdata_ff,
  output reg pa_rsvd_ff,
  output reg [19:0] pa_addr_ff,
  output reg [2:0] rom_zone_ff,
  output reg [15:0] da_rdata_ff,
  output reg da_valid_ff,
  output reg da_ext_ff,
  output reg da_we_ff,
  output reg [15:0] da_wdata_ff,
  output reg [15:0] da_addr_ff,
  output reg pc_load_ff,
  output reg [19:0] pc_target_ff,
  output reg int_en_ff,
  output reg [15:0] program_page_extension_ff
);

  reg [15:0] rom_mem [0:4095];
  reg [15:0] ram0_mem [0:4095];
  reg [15:0] ram1_mem [0:4095];

  reg boot_s1_ff;
  reg boot_s2_ff;
  reg boot_mode_ff;
  reg [8:0] vec_ptr_ff;
  reg ram_overlay_ff;
  reg rst_seen_ff;

  // program port: table access has priority over the fetch
  wire pa_go = tbl_req | pf_req;
  wire pa_wr = tbl_req & tbl_we;
  wire [19:0] pa_addr = tbl_req ? accum : {program_page_extension_ff[3:0], pf_pc};
  wire [3:0] pa_page = pa_addr[19:16];
  wire [15:0] pa_lo = pa_addr[15:0];
  wire pa_low_map = (pa_lo < `LOW16K_TOP) & ((pa_page == 4'h0) | ram_overlay_ff);
  wire pa_ram0 = pa_low_map & (pa_lo[15:12] == `NIB_RAM0);
  wire pa_ram1 = pa_low_map & (pa_lo[15:12] == `NIB_RAM1);
  wire pa_rom = (pa_page == 4'h0) & ~boot_mode_ff & (pa_lo[15:12] == `NIB_ROM);
  wire pa_ext = ~pa_low_map & ~pa_rom;
  wire pa_rsv = (pa_low_map & ~pa_ram0 & ~pa_ram1) | (pa_rom & (pa_lo < `ROM_BOOT));

  // data port decode
  wire d_scr = (da_addr >= `SCR_LO) & (da_addr <= `SCR_HI);
  wire d_ram0 = d_scr | (da_addr[15:12] == `NIB_RAM0);
  wire d_ram1 = da_addr[15:12] == `NIB_RAM1;
  wire d_mmr = (da_addr < `MMR_TOP) & ~d_scr;
  wire d_ext = ~d_mmr & ~d_ram0 & ~d_ram1;
  wire d_page_ext = da_addr == `ADDR_PAGE_EXT;
  wire d_stat = da_addr == `ADDR_MODE_STAT;
  wire [15:0] stat_val = {vec_ptr_ff, boot_mode_ff, ram_overlay_ff, 5'h00};

  reg [2:0] nxt_zone;
  always @* begin
    if (!pa_rom) begin
      nxt_zone = `ZONE_NONE;
    end else if (pa_lo >= `ROM_VECT) begin
      nxt_zone = `ZONE_VECT;
    end else if (pa_lo >= `ROM_TEST) begin
      nxt_zone = `ZONE_TEST;
    end else if (pa_lo >= `ROM_SINE) begin
      nxt_zone = `ZONE_SINE;
    end else if (pa_lo >= `ROM_ALAW) begin
      nxt_zone = `ZONE_ALAW;
    end else if (pa_lo >= `ROM_MULAW) begin
      nxt_zone = `ZONE_MULAW;
    end else if (pa_lo >= `ROM_BOOT) begin
      nxt_zone = `ZONE_BOOT;
    end else begin
      nxt_zone = `ZONE_RSVD;
    end
  end

  // boot pin crosses in from outside
  always @(posedge mclk) begin
    boot_s1_ff <= boot_mode_select_pin;
    boot_s2_ff <= boot_s1_ff;
  end

  // mode, pointer and page registers
  always @(posedge mclk) begin
    if (!rst_b) begin
      boot_mode_ff <= boot_s2_ff; // pin level held through reset
      vec_ptr_ff <= `VEC_PTR_RST;
      ram_overlay_ff <= `OVERLAY_RST;
      program_page_extension_ff <= `PAGE_EXT_RST;
    end else begin
      if (da_req & da_we & d_stat) begin
        vec_ptr_ff <= da_wdata[`STAT_VPTR_HI:`STAT_VPTR_LO];
        boot_mode_ff <= da_wdata[`STAT_BOOT_MODE];
        ram_overlay_ff <= da_wdata[`STAT_OVERLAY];
      end
      // far ops win over a same-cycle page register write
      if (far_req) begin
        case (far_op)
          `OP_FAR_BR, `OP_FAR_CALL: begin
            program_page_extension_ff <= {12'h000, far_imm[19:16]};
          end
          `OP_FAR_BR_ACC, `OP_FAR_CALL_ACC: begin
            program_page_extension_ff <= {12'h000, accum[19:16]};
          end
          `OP_FAR_RET, `OP_FAR_RET_IE: begin
            program_page_extension_ff <= {12'h000, far_ret[19:16]};
          end
          default: begin
            program_page_extension_ff <= program_page_extension_ff;
          end
        endcase
      end else if (da_req & da_we & d_page_ext) begin
        program_page_extension_ff <= da_wdata;
      end
      // vectors and table ops never touch the page
    end
  end

  // pc redirect: reset vector, interrupt vectors, far transfers
  always @(posedge mclk) begin
    if (!rst_b) begin
      rst_seen_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      pc_target_ff <= 20'h0_0000;
      int_en_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
      int_en_ff <= far_req & (far_op == `OP_FAR_RET_IE);
      if (!rst_seen_ff) begin
        pc_load_ff <= 1'b1;
        pc_target_ff <= {4'h0, `VEC_PTR_RST, 7'h00};
      end else if (far_req) begin
        pc_load_ff <= 1'b1;
        case (far_op)
          `OP_FAR_BR, `OP_FAR_CALL: pc_target_ff <= far_imm;
          `OP_FAR_BR_ACC, `OP_FAR_CALL_ACC: pc_target_ff <= accum;
          default: pc_target_ff <= far_ret;
        endcase
      end else if (vec_req) begin
        pc_load_ff <= 1'b1;
        // vector stays in current page, four words per slot
        pc_target_ff <= {program_page_extension_ff[3:0], vec_ptr_ff, vec_num, 2'b00};
      end else begin
        pc_load_ff <= 1'b0;
      end
    end
  end

  // mask contents loaded through the program-time port only
  always @(posedge mclk) begin
    if (rom_load_en) begin
      rom_mem[rom_load_addr] <= rom_load_data;
    end
  end

  // block 0: program port and data port in the same cycle
  reg [15:0] ram0_prd_ff;
  reg [15:0] ram0_drd_ff;
  always @(posedge mclk) begin
    ram0_prd_ff <= ram0_mem[pa_lo[11:0]];
    ram0_drd_ff <= ram0_mem[da_addr[11:0]];
    if (pa_go & pa_wr & pa_ram0) begin
      ram0_mem[pa_lo[11:0]] <= tbl_wdata;
    end
    // data write lands last if both write the same word
    if (da_req & da_we & d_ram0) begin
      ram0_mem[da_addr[11:0]] <= da_wdata;
    end
  end

  reg [15:0] ram1_prd_ff;
  reg [15:0] ram1_drd_ff;
  always @(posedge mclk) begin
    ram1_prd_ff <= ram1_mem[pa_lo[11:0]];
    ram1_drd_ff <= ram1_mem[da_addr[11:0]];
    if (pa_go & pa_wr & pa_ram1) begin
      ram1_mem[pa_lo[11:0]] <= tbl_wdata;
    end
    if (da_req & da_we & d_ram1) begin
      ram1_mem[da_addr[11:0]] <= da_wdata;
    end
  end

  reg [15:0] rom_rd_ff;
  always @(posedge mclk) begin
    rom_rd_ff <= rom_mem[pa_lo[11:0]];
  end

  // stage one: capture decode alongside the array read
  reg pa_hit_ff;
  reg [1:0] pa_src_ff;
  reg da_hit_ff;
  reg [1:0] da_src_ff;
  reg [15:0] da_reg_ff;
  always @(posedge mclk) begin
    if (!rst_b) begin
      pa_hit_ff <= 1'b0;
      pa_src_ff <= 2'h0;
      da_hit_ff <= 1'b0;
      da_src_ff <= 2'h0;
      da_reg_ff <= 16'h0000;
      pa_ext_ff <= 1'b0;
      pa_we_ff <= 1'b0;
      pa_wdata_ff <= 16'h0000;
      pa_rsvd_ff <= 1'b0;
      pa_addr_ff <= 20'h0_0000;
      rom_zone_ff <= `ZONE_NONE;
      da_ext_ff <= 1'b0;
      da_we_ff <= 1'b0;
      da_wdata_ff <= 16'h0000;
      da_addr_ff <= 16'h0000;
    end else begin
      pa_hit_ff <= pa_go & ~pa_wr & ~pa_ext;
      pa_src_ff <= pa_ram0 ? 2'h1 : (pa_ram1 ? 2'h2 : (pa_rom & ~pa_rsv ? 2'h3 : 2'h0));
      pa_ext_ff <= pa_go & pa_ext;
      pa_we_ff <= pa_go & pa_wr;
      pa_wdata_ff <= tbl_wdata;
      pa_rsvd_ff <= pa_go & pa_rsv;
      pa_addr_ff <= pa_addr;
      rom_zone_ff <= pa_go ? nxt_zone : `ZONE_NONE;
      da_hit_ff <= da_req & ~da_we & ~d_ext;
      da_src_ff <= d_ram0 ? 2'h1 : (d_ram1 ? 2'h2 : 2'h0);
      // unmapped registers in the low area read zero
      da_reg_ff <= d_page_ext ? program_page_extension_ff : (d_stat ? stat_val : 16'h0000);
      da_ext_ff <= da_req & d_ext;
      da_we_ff <= da_req & da_we;
      da_wdata_ff <= da_wdata;
      da_addr_ff <= da_addr;
    end
  end

  // stage two: steer read data to the answer registers
  always @(posedge mclk) begin
    if (!rst_b) begin
      pa_valid_ff <= 1'b0;
      pa_rdata_ff <= 16'h0000;
      da_valid_ff <= 1'b0;
      da_rdata_ff <= 16'h0000;
    end else begin
      pa_valid_ff <= pa_hit_ff;
      case (pa_src_ff)
        2'h1: pa_rdata_ff <= ram0_prd_ff;
        2'h2: pa_rdata_ff <= ram1_prd_ff;
        2'h3: pa_rdata_ff <= rom_rd_ff;
        default: pa_rdata_ff <= 16'h0000;
      endcase
      da_valid_ff <= da_hit_ff;
      case (da_src_ff)
        2'h1: da_rdata_ff <= ram0_drd_ff;
        2'h2: da_rdata_ff <= ram1_drd_ff;
        default: da_rdata_ff <= da_reg_ff;
      endcase
    end
  end

endmodule
`default_nettype wire

/* core/mmap_regs.vh */
// address map, field layout, reset values and opcodes of the memory map decoder
`ifndef MMAP_REGS_VH
`define MMAP_REGS_VH
`define ADDR_PAGE_EXT 16'h001E
`define ADDR_MODE_STAT 16'h001D
`define PAGE_EXT_RST 16'h0000
`define VEC_PTR_RST 9'h1FF
`define OVERLAY_RST 1'b0
`define STAT_VPTR_HI 15
`define STAT_VPTR_LO 7
`define STAT_BOOT_MODE 6
`define STAT_OVERLAY 5
`define SCR_LO 16'h0060
`define SCR_HI 16'h007F
`define MMR_TOP 16'h0080
`define LOW16K_TOP 16'h4000
`define NIB_RAM0 4'h1
`define NIB_RAM1 4'h2
`define NIB_ROM 4'hF
`define ROM_BOOT 16'hF800
`define ROM_MULAW 16'hFC00
`define ROM_ALAW 16'hFD00
`define ROM_SINE 16'hFE00
`define ROM_TEST 16'hFF00
`define ROM_VECT 16'hFF80
`define ZONE_RSVD 3'h0
`define ZONE_BOOT 3'h1
`define ZONE_MULAW 3'h2
`define ZONE_ALAW 3'h3
`define ZONE_SINE 3'h4
`define ZONE_TEST 3'h5
`define ZONE_VECT 3'h6
`define ZONE_NONE 3'h7
`define OP_FAR_BR 3'h0
`define OP_FAR_BR_ACC 3'h1
`define OP_FAR_CALL 3'h2
`define OP_FAR_CALL_ACC 3'h3
`define OP_FAR_RET 3'h4
`define OP_FAR_RET_IE 3'h5
`endif

/* tb/core_model.sv */
// processor core model issuing fetch, table, data, far and vector requests
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic mclk,
  output var logic pf_req,
  output var logic [15:0] pf_pc,
  output var logic tbl_req,
  output var logic tbl_we,
  output var logic [15:0] tbl_wdata,
  output var logic [19:0] accum,
  output var logic da_req,
  output var logic da_we,
  output var logic [15:0] da_addr,
  output var logic [15:0] da_wdata,
  output var logic far_req,
  output var logic [2:0] far_op,
  output var logic [19:0] far_imm,
  output var logic [19:0] far_ret,
  output var logic vec_req,
  output var logic [4:0] vec_num,
  output var logic rom_load_en,
  output var logic [11:0] rom_load_addr,
  output var logic [15:0] rom_load_data
);
  initial {pf_req, pf_pc, tbl_req, tbl_we, tbl_wdata, accum, da_req, da_we, da_addr} = '0;
  initial {da_wdata, far_req, far_op, far_imm, far_ret, vec_req, vec_num, rom_load_en} = '0;
  initial {rom_load_addr, rom_load_data} = '0;
  // address lines flip once released so a stale value never looks valid
  task fetch(input logic [15:0] a);
    @(posedge mclk) {pf_req, pf_pc} <= {1'b1, a};
    @(posedge mclk) {pf_req, pf_pc} <= {1'b0, ~a};
  endtask
  task tbl(input logic w, input logic [19:0] a, input logic [15:0] d);
    @(posedge mclk) {tbl_req, tbl_we, accum, tbl_wdata} <= {1'b1, w, a, d};
    @(posedge mclk) {tbl_req, accum} <= {1'b0, ~a};
  endtask
  task dacc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk) {da_req, da_we, da_addr, da_wdata} <= {1'b1, w, a, d};
    @(posedge mclk) {da_req, da_addr} <= {1'b0, ~a};
  endtask
  // each source gets its own value so a wrong pick shows up
  task far(input logic [2:0] op, input logic [19:0] t);
    @(posedge mclk) {far_req, far_op, far_imm} <= {1'b1, op, t};
    {accum, far_ret} <= {t ^ 20'h1_1111, t ^ 20'h2_2222};
    @(posedge mclk) far_req <= 1'b0;
  endtask
  task vec(input logic [4:0] n);
    @(posedge mclk) {vec_req, vec_num} <= {1'b1, n};
    @(posedge mclk) vec_req <= 1'b0;
  endtask
  task load(input logic [11:0] a, input logic [15:0] d);
    if (a[11:7] != 5'h1E) begin
      @(posedge mclk) {rom_load_en, rom_load_addr, rom_load_data} <= {1'b1, a, d};
      @(posedge mclk) rom_load_en <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* tb/mmap_checker.sv */
// concurrent checks on the memory map decoder ports
`timescale 1ns/100ps
`default_nettype none
module mmap_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pf_req,
  input wire logic [15:0] pf_pc,
  input wire logic tbl_req,
  input wire logic [19:0] accum,
  input wire logic da_req,
  input wire logic da_we,
  input wire logic [15:0] da_addr,
  input wire logic far_req,
  input wire logic [2:0] far_op,
  input wire logic [19:0] far_ret,
  input wire logic vec_req,
  input wire logic [4:0] vec_num,
  input wire logic [19:0] pa_addr_ff,
  input wire logic da_valid_ff,
  input wire logic pc_load_ff,
  input wire logic [19:0] pc_target_ff,
  input wire logic int_en_ff,
  input wire logic [15:0] program_page_extension_ff
);
  wire logic [3:0] pg = program_page_extension_ff[3:0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence ram_rd;
    da_req && !da_we && da_addr[15:12] == 4'h2;
  endsequence
  reset_vector_a: assert property ($rose(rst_b)
    |=> pc_load_ff && pc_target_ff == 20'h0_FF80) else $error("reset vector wrong");
  far_page_a: assert property (far_req |=> pc_load_ff && pg == pc_target_ff[19:16])
    else $error("far page wrong");
  far_ret_a: assert property (far_req && far_op[2] |=> pc_target_ff == $past(far_ret)
    && int_en_ff == ($past(far_op) == 3'h5)) else $error("far return wrong");
  page_hold_a: assert property (!far_req && !(da_req && da_we && da_addr == 16'h001E)
    |=> $stable(program_page_extension_ff)) else $error("page changed");
  fetch_addr_a: assert property (pf_req && !tbl_req
    |=> pa_addr_ff == {$past(pg), $past(pf_pc)}) else $error("fetch address wrong");
  tbl_addr_a: assert property (tbl_req |=> pa_addr_ff == $past(accum))
    else $error("table address wrong");
  vec_slot_a: assert property (vec_req && !far_req
    |=> pc_load_ff && pc_target_ff[6:0] == {$past(vec_num), 2'b00}) else $error("vector slot wrong");
  ram_read_a: assert property (ram_rd |-> ##2 da_valid_ff)
    else $error("ram read not answered");
endmodule
bind mem_map_decoder mmap_checker u_chk (.*);
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the memory map decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic boot_mode_select_pin = 1'b0;
  wire logic pf_req, tbl_req, tbl_we, da_req, da_we, far_req, vec_req, rom_load_en;
  wire logic [15:0] pf_pc, tbl_wdata, da_addr, da_wdata, rom_load_data;
  wire logic [19:0] accum, far_imm, far_ret;
  wire logic [2:0] far_op;
  wire logic [4:0] vec_num;
  wire logic [11:0] rom_load_addr;
  logic [15:0] pa_rdata_ff, da_rdata_ff, program_page_extension_ff;
  logic pa_valid_ff, pa_ext_ff, da_valid_ff, da_ext_ff, pc_load_ff, int_en_ff;
  logic [19:0] pa_addr_ff, pc_target_ff, e;
  logic [2:0] rom_zone_ff;
  logic pa_we_ff, pa_rsvd_ff, da_we_ff;
  logic [15:0] pa_wdata_ff, da_wdata_ff, da_addr_ff;
  logic [15:0] zaddr [7] = '{16'hF000, 16'hF800, 16'hFC00, 16'hFD00, 16'hFE00, 16'hFF00, 16'hFF80};
  int mismatches = 0;
  int samples_checked = 0;
  always #25 mclk = ~mclk;
  core_model u_core (.*);
  mem_map_decoder u_dut (.*);
  task chk(input logic [19:0] g, input logic [19:0] x);
    samples_checked++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task rd(input logic [15:0] a, input logic [19:0] x);
    u_core.dacc(1'b0, a, 16'h0);
    @(posedge mclk) #1 chk(da_valid_ff, 1'b1);
    chk(da_rdata_ff, x);
  endtask
  task pfr(input logic [15:0] a, input logic [19:0] x);
    u_core.fetch(a);
    @(posedge mclk) #1 chk(pa_valid_ff, 1'b1);
    chk(pa_rdata_ff, x);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk) #1 chk(pc_load_ff, 1'b1);
    chk(pc_target_ff, 20'h0_FF80);
    rd(16'h001E, 20'h0_0000);
    u_core.load(12'hF00, 16'hDEAD);
    u_core.load(12'h800, 16'hA5A5);
    for (int i = 0; i < 7; i++) begin
      u_core.fetch(zaddr[i]);
      #1 chk(rom_zone_ff, 20'(i));
      chk(pa_rsvd_ff, i == 0);
    end
    pfr(16'hF800, 20'h0_A5A5);
    u_core.dacc(1'b1, 16'h1065, 16'h1111);
    u_core.dacc(1'b1, 16'h2005, 16'h2222);
    rd(16'h0065, 20'h0_1111);
    pfr(16'h0065, 20'h0_0000);
    fork pfr(16'h2005, 20'h0_2222); rd(16'h2005, 20'h0_2222); join
    u_core.dacc(1'b1, 16'h8000, 16'h4444);
    #1 chk(da_ext_ff, 1'b1);
    chk(da_we_ff, 1'b1);
    chk(da_wdata_ff, 20'h0_4444);
    chk(da_addr_ff, 20'h0_8000);
    u_core.tbl(1'b1, 20'h0_2006, 16'h3333);
    #1 chk(pa_we_ff, 1'b1);
    chk(pa_wdata_ff, 20'h0_3333);
    rd(16'h2006, 20'h0_3333);
    $display("rom and ram test done");
    u_core.dacc(1'b1, 16'h001E, 16'h0003);
    rd(16'h001E, 20'h0_0003);
    u_core.fetch(16'h5000);
    #1 chk(pa_addr_ff, 20'h3_5000);
    chk(pa_ext_ff, 1'b1);
    u_core.tbl(1'b0, 20'h4_1065, 16'h0);
    #1 chk(pa_addr_ff, 20'h4_1065);
    chk(pa_ext_ff, 1'b1);
    u_core.vec(5'd2);
    #1 chk(pc_target_ff, 20'h3_FF88);
    chk(program_page_extension_ff, 20'h0_0003);
    $display("page test done");
    for (int i = 0; i < 6; i++) begin
      u_core.far(i[2:0], 20'h1_0040);
      e = (i > 3) ? 20'h3_2262 : i[0] ? 20'h0_1151 : 20'h1_0040;
      #1 chk(pc_target_ff, e);
      chk(program_page_extension_ff, {16'h0, e[19:16]});
      chk(int_en_ff, i == 5);
    end
    u_core.dacc(1'b1, 16'h001D, 16'h00A0);
    u_core.vec(5'd5);
    #1 chk(pc_target_ff, 20'h3_0094);
    pfr(16'h1065, 20'h0_1111);
    $display("far and vector test done");
    @(posedge mclk) {rst_b, boot_mode_select_pin} <= 2'b01;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk) #1 chk(pc_load_ff, 1'b1);
    chk(pc_target_ff, 20'h0_FF80);
    rd(16'h001D, 20'h0_FFC0);
    u_core.fetch(16'hFF80);
    #1 chk(rom_zone_ff, 20'h0_0007);
    $display("boot pin test done");
    wrap_up;
  end
  // a hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (4000) @(posedge mclk);
    mismatches++;
    wrap_up;
  end
endmodule
`default_nettype wire
